// ---- rtl/mua_pkg.sv ----
// constants, field layout and types shared by the multiply-accumulate unit
package mua_pkg;
	// datapath widths
	localparam int ACC_W = 40;
	localparam int DATA_W = 16;
	localparam int OPR_W = 17;
	localparam int PROD_W = 32;
	localparam int RAW_W = 34;
	localparam int SUM_W = 41;
	localparam int INSTR_W = 32;
	localparam int NUM_ACC = 4;
	localparam int NUM_TMP = 4;
	localparam int SEL_W = 2;
	localparam int SIZE_W = 3;

	// first opcode byte patterns; the 7-bit ones leave the E bit out
	localparam logic [6:0] OP_ACC_T = 7'h2B;
	localparam logic [6:0] OP_SWAP = 7'h2C;
	localparam logic [6:0] OP_IMM8 = 7'h0F;
	localparam logic [7:0] OP_IMM16 = 8'h79;
	localparam logic [7:0] OP_COEF = 8'hD1;
	localparam logic [1:0] COEF_TAG = 2'h1;

	// field positions inside the left-aligned instruction word
	localparam int POS_E = 24;
	localparam int POS_R_DST = 22;
	localparam int POS_R_SRC = 20;
	localparam int POS_R_TMP = 18;
	localparam int POS_R_TAG = 17;
	localparam int POS_R_RND = 16;
	localparam int POS_IMM8 = 16;
	localparam int POS_B2_SRC = 14;
	localparam int POS_B2_DST = 12;
	localparam int POS_B2_TMP = 10;
	localparam int POS_B2_TAG = 9;
	localparam int POS_B2_RND = 8;
	localparam int POS_IMM16 = 8;
	localparam int POS_B3_SRC = 6;
	localparam int POS_B3_DST = 4;
	localparam int POS_B3_TMP = 2;
	localparam int POS_B3_TAG = 1;
	localparam int POS_B3_RND = 0;
	localparam int POS_C_STORE = 15;
	localparam int POS_C_RND = 14;
	localparam int POS_C_DST = 12;
	localparam int POS_C_TAG = 10;

	// instruction sizes in bytes
	localparam logic [2:0] SIZE_REG = 3'h2;
	localparam logic [2:0] SIZE_IMM8 = 3'h3;
	localparam logic [2:0] SIZE_IMM16 = 3'h4;
	localparam logic [2:0] SIZE_COEF = 3'h3;

	// arithmetic constants and reset values
	localparam logic [SUM_W-1:0] ROUND_ADD = 41'h00000008000;
	localparam logic [ACC_W-1:0] SAT32_POS = 40'h007FFFFFFF;
	localparam logic [ACC_W-1:0] SAT32_NEG = 40'hFF80000000;
	localparam logic [ACC_W-1:0] SAT40_POS = 40'h7FFFFFFFFF;
	localparam logic [ACC_W-1:0] SAT40_NEG = 40'h8000000000;
	localparam logic [PROD_W-1:0] MUL_SAT = 32'h7FFFFFFF;
	localparam logic [OPR_W-1:0] MUL_OVF_OPR = 17'h18000;
	localparam logic [DATA_W-1:0] RND_TIE = 16'h8000;
	localparam logic [ACC_W-1:0] ACC_RST = 40'h0000000000;
	localparam logic [DATA_W-1:0] TMP_RST = 16'h0000;
	localparam logic [SEL_W-1:0] TMP3_IDX = 2'h3;

	typedef enum logic [2:0] {
		form_none,
		form_acc_t,
		form_swap,
		form_imm8,
		form_imm16,
		form_coef
	} mua_form_e;
endpackage

// ---- rtl/mua_mul_if.sv ----
// operand and product carrier between the accumulate core and the multiplier
interface mua_mul_if;
	logic signed [16:0] opr_a;
	logic signed [16:0] opr_b;
	logic frac_en;
	logic psat_en;
	logic [31:0] product;
	logic mul_ovf;
	modport core (output opr_a, output opr_b, output frac_en, output psat_en, input product, input mul_ovf);
	modport mul (input opr_a, input opr_b, input frac_en, input psat_en, output product, output mul_ovf);
endinterface

// ---- rtl/mua_mul.sv ----
// 17x17 signed multiplier with fractional shift and product saturation
module mua_mul (
	mua_mul_if.mul m
);
	logic signed [mua_pkg::RAW_W-1:0] raw;
	logic [mua_pkg::RAW_W-1:0] shifted;

	// for sign-extended 16-bit operands only (-1.0)*(-1.0) in fractional form leaves the 32-bit range
	always_comb begin
		raw = m.opr_a * m.opr_b;
		shifted = m.frac_en ? {raw[mua_pkg::RAW_W-2:0], 1'b0} : raw;
		m.mul_ovf = m.frac_en && (m.opr_a == mua_pkg::MUL_OVF_OPR) && (m.opr_b == mua_pkg::MUL_OVF_OPR);
		m.product = (m.psat_en && m.mul_ovf) ? mua_pkg::MUL_SAT : shifted[mua_pkg::PROD_W-1:0];
	end
endmodule

// ---- rtl/mua_mac_unit.sv ----
// multiply-accumulate unit: decode, accumulate, round, saturate, flags
module mua_mac_unit (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [15:0] smem_data_i,
	input wire logic [15:0] coeff_data_i,
	input wire logic coeff_external_i,
	input wire logic fractional_mode_i,
	input wire logic mult_saturate_mode_i,
	input wire logic round_mode_i,
	input wire logic wide_overflow_mode_i,
	input wire logic datapath_saturate_enable_i,
	input wire logic legacy_compat_mode_i,
	input wire logic [3:0] ovf_clear_i,
	input wire logic reg_wr_i,
	input wire logic reg_wr_acc_i,
	input wire logic [1:0] reg_wr_idx_i,
	input wire logic [39:0] reg_wr_data_i,
	output logic [3:0][39:0] acc_o,
	output logic [3:0][15:0] temp_o,
	output logic [3:0] ovf_flag_o,
	output logic done_o,
	output logic illegal_o,
	output logic bus_error_o,
	output logic paired_o,
	output logic [2:0] size_o,
	output logic legacy_exact_o
);
	mua_mul_if mif ();

	mua_pkg::mua_form_e form;
	logic [1:0] src_sel;
	logic [1:0] dst_sel;
	logic [1:0] tmp_sel;
	logic rnd;
	logic store_tmp3;
	logic e_bit;
	logic [2:0] next_size;
	logic exec;
	logic berr;
	logic [39:0] addend;
	logic [39:0] prod40;
	logic [40:0] wide;
	logic [39:0] rounded;
	logic ovf;
	logic [39:0] result;
	logic [3:0] ovf_set;

	// widen a 16-bit word to a 17-bit signed multiplier operand
	function automatic logic [16:0] sext17(input logic [15:0] v);
		sext17 = {v[15], v};
	endfunction

	mua_mul u_mul (
		.m(mif.mul)
	);

	// opcode recognition; a wrong tag bit means the word is not ours
	always_comb begin
		form = mua_pkg::form_none;
		src_sel = 2'h0;
		dst_sel = 2'h0;
		tmp_sel = 2'h0;
		rnd = 1'b0;
		store_tmp3 = 1'b0;
		e_bit = instr_i[mua_pkg::POS_E];
		next_size = 3'h0;
		if (instr_i[31:25] == mua_pkg::OP_ACC_T && !instr_i[mua_pkg::POS_R_TAG]) begin
			form = mua_pkg::form_acc_t;
		end else if (instr_i[31:25] == mua_pkg::OP_SWAP && instr_i[mua_pkg::POS_R_TAG]) begin
			form = mua_pkg::form_swap;
		end else if (instr_i[31:25] == mua_pkg::OP_IMM8 && instr_i[mua_pkg::POS_B2_TAG]) begin
			form = mua_pkg::form_imm8;
		end else if (instr_i[31:24] == mua_pkg::OP_IMM16 && instr_i[mua_pkg::POS_B3_TAG]) begin
			form = mua_pkg::form_imm16;
		end else if (instr_i[31:24] == mua_pkg::OP_COEF && instr_i[mua_pkg::POS_C_TAG +: 2] == mua_pkg::COEF_TAG) begin
			form = mua_pkg::form_coef;
		end
		unique case (form)
			mua_pkg::form_acc_t, mua_pkg::form_swap: begin
				dst_sel = instr_i[mua_pkg::POS_R_DST +: 2];
				src_sel = instr_i[mua_pkg::POS_R_SRC +: 2];
				tmp_sel = instr_i[mua_pkg::POS_R_TMP +: 2];
				rnd = instr_i[mua_pkg::POS_R_RND];
				next_size = mua_pkg::SIZE_REG;
			end
			mua_pkg::form_imm8: begin
				src_sel = instr_i[mua_pkg::POS_B2_SRC +: 2];
				dst_sel = instr_i[mua_pkg::POS_B2_DST +: 2];
				tmp_sel = instr_i[mua_pkg::POS_B2_TMP +: 2];
				rnd = instr_i[mua_pkg::POS_B2_RND];
				next_size = mua_pkg::SIZE_IMM8;
			end
			mua_pkg::form_imm16: begin
				src_sel = instr_i[mua_pkg::POS_B3_SRC +: 2];
				dst_sel = instr_i[mua_pkg::POS_B3_DST +: 2];
				tmp_sel = instr_i[mua_pkg::POS_B3_TMP +: 2];
				rnd = instr_i[mua_pkg::POS_B3_RND];
				next_size = mua_pkg::SIZE_IMM16;
				e_bit = 1'b0;
			end
			mua_pkg::form_coef: begin
				dst_sel = instr_i[mua_pkg::POS_C_DST +: 2];
				src_sel = instr_i[mua_pkg::POS_C_DST +: 2];
				rnd = instr_i[mua_pkg::POS_C_RND];
				store_tmp3 = instr_i[mua_pkg::POS_C_STORE];
				next_size = mua_pkg::SIZE_COEF;
				e_bit = 1'b0;
			end
			mua_pkg::form_none: begin
				e_bit = 1'b0;
			end
		endcase
	end

	// coefficient bus reaches internal memory only; an external hit aborts
	assign berr = instr_valid_i && (form == mua_pkg::form_coef) && coeff_external_i;
	// no busy state, so a repeated instruction executes every cycle
	assign exec = instr_valid_i && (form != mua_pkg::form_none) && !berr;

	// multiplier operand steering per form
	always_comb begin
		mif.opr_a = sext17(temp_o[tmp_sel]);
		mif.opr_b = sext17(temp_o[tmp_sel]);
		addend = acc_o[src_sel];
		unique case (form)
			mua_pkg::form_acc_t: begin
				mif.opr_a = acc_o[src_sel][32:16];
				addend = acc_o[dst_sel];
			end
			mua_pkg::form_swap: begin
				mif.opr_a = acc_o[dst_sel][32:16];
				addend = acc_o[src_sel];
			end
			mua_pkg::form_imm8: begin
				mif.opr_b = {{9{instr_i[mua_pkg::POS_IMM8 + 7]}}, instr_i[mua_pkg::POS_IMM8 +: 8]};
			end
			mua_pkg::form_imm16: begin
				mif.opr_b = sext17(instr_i[mua_pkg::POS_IMM16 +: 16]);
			end
			mua_pkg::form_coef: begin
				mif.opr_a = sext17(smem_data_i);
				mif.opr_b = sext17(coeff_data_i);
				addend = acc_o[dst_sel];
			end
			mua_pkg::form_none: begin
				addend = acc_o[src_sel];
			end
		endcase
		mif.frac_en = fractional_mode_i;
		mif.psat_en = mult_saturate_mode_i;
	end

	// add, round and check; one extra bit keeps the true sign for saturation
	always_comb begin
		prod40 = {{8{mif.product[31]}}, mif.product};
		wide = {addend[39], addend} + {prod40[39], prod40} + (rnd ? mua_pkg::ROUND_ADD : 41'h00000000000);
		rounded = wide[39:0];
		if (rnd) begin
			rounded[15:0] = 16'h0000;
			// convergent mode breaks exact ties toward even
			if (round_mode_i && (addend[15:0] + prod40[15:0]) == mua_pkg::RND_TIE) begin
				rounded[16] = 1'b0;
			end
		end
		// narrow mode checks bit 31, which keeps legacy results unchanged
		if (wide_overflow_mode_i) begin
			ovf = wide[40] != wide[39];
		end else begin
			ovf = !((&wide[40:31]) || !(|wide[40:31]));
		end
		result = rounded;
		if (ovf && datapath_saturate_enable_i) begin
			if (wide_overflow_mode_i) begin
				result = wide[40] ? mua_pkg::SAT40_NEG : mua_pkg::SAT40_POS;
			end else begin
				result = wide[40] ? mua_pkg::SAT32_NEG : mua_pkg::SAT32_POS;
			end
		end
	end

	// accumulators; execution wins over a same-cycle register write
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_o <= '{default: mua_pkg::ACC_RST};
		end else begin
			if (reg_wr_i && reg_wr_acc_i && !(exec && reg_wr_idx_i == dst_sel)) begin
				acc_o[reg_wr_idx_i] <= reg_wr_data_i;
			end
			if (exec) begin
				acc_o[dst_sel] <= result;
			end
		end
	end

	// temporary registers with the optional memory-operand copy
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			temp_o <= '{default: mua_pkg::TMP_RST};
		end else begin
			if (reg_wr_i && !reg_wr_acc_i && !(exec && store_tmp3 && reg_wr_idx_i == mua_pkg::TMP3_IDX)) begin
				temp_o[reg_wr_idx_i] <= reg_wr_data_i[15:0];
			end
			if (exec && store_tmp3) begin
				temp_o[mua_pkg::TMP3_IDX] <= smem_data_i;
			end
		end
	end

	// overflow set strobes, one per accumulator
	generate
		for (genvar i = 0; i < mua_pkg::NUM_ACC; i++) begin : g_flag
			assign ovf_set[i] = exec && ovf && (dst_sel == 2'(i));
		end
	endgenerate

	// sticky overflow flags; one process so the flag word has a single driver
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ovf_flag_o <= 4'h0;
		end else begin
			ovf_flag_o <= (ovf_flag_o & ~ovf_clear_i) | ovf_set; // set wins over clear
		end
	end

	// per-instruction status pulses
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			done_o <= 1'b0;
			illegal_o <= 1'b0;
			bus_error_o <= 1'b0;
			paired_o <= 1'b0;
			size_o <= 3'h0;
			legacy_exact_o <= 1'b0;
		end else begin
			done_o <= exec;
			illegal_o <= instr_valid_i && (form == mua_pkg::form_none);
			bus_error_o <= berr;
			paired_o <= exec && e_bit;
			size_o <= exec ? next_size : 3'h0;
			legacy_exact_o <= exec && legacy_compat_mode_i && !wide_overflow_mode_i;
		end
	end

	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);

	logic signed [33:0] chk_acct;
	logic signed [33:0] chk_swap;
	assign chk_acct = $signed(acc_o[src_sel][32:16]) * $signed(sext17(temp_o[tmp_sel]));
	assign chk_swap = $signed(acc_o[dst_sel][32:16]) * $signed(sext17(temp_o[tmp_sel]));
	logic signed [33:0] chk_coef;
	logic [1:0] chk_dst_q;
	assign chk_coef = $signed(sext17(smem_data_i)) * $signed(sext17(coeff_data_i));
	// destination one cycle back, so a later clear is matched to the right flag
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chk_dst_q <= 2'h0;
		end else begin
			chk_dst_q <= dst_sel;
		end
	end

	sequence s_plain(mua_pkg::mua_form_e f);
		exec && form == f && !rnd && !fractional_mode_i && !ovf;
	endsequence

	sequence s_overflow;
		exec && ovf;
	endsequence

	acct_sum_a: assert property (s_plain(mua_pkg::form_acc_t) |=>
		acc_o[$past(dst_sel)] == $past(acc_o[dst_sel] + {{6{chk_acct[33]}}, chk_acct}))
		else $error("acc times temp sum wrong");
	swap_sum_a: assert property (s_plain(mua_pkg::form_swap) |=>
		acc_o[$past(dst_sel)] == $past(acc_o[src_sel] + {{6{chk_swap[33]}}, chk_swap}))
		else $error("swapped form sum wrong");
	imm16_oper_a: assert property (exec && form == mua_pkg::form_imm16 |->
		mif.opr_b[15:0] == instr_i[23:8] && mif.opr_b[16] == instr_i[23])
		else $error("16-bit constant operand wrong");
	frac_shift_a: assert property (fractional_mode_i && !(mult_saturate_mode_i && mif.mul_ovf) |->
		mif.product[0] == 1'b0)
		else $error("fractional product not shifted");
	mul_sat_a: assert property (mult_saturate_mode_i && fractional_mode_i &&
		mif.opr_a == mua_pkg::MUL_OVF_OPR && mif.opr_b == mua_pkg::MUL_OVF_OPR |-> mif.product == mua_pkg::MUL_SAT)
		else $error("product not saturated");
	sext_prod_a: assert property (exec |-> prod40[39:32] == {8{mif.product[31]}})
		else $error("product not sign extended");
	round_low_a: assert property (exec && rnd && !ovf |=> acc_o[$past(dst_sel)][15:0] == 16'h0000)
		else $error("rounded result has low bits");
	ovf_flag_a: assert property (s_overflow |=> ovf_flag_o[$past(dst_sel)] ##1
		(ovf_flag_o[$past(dst_sel, 2)] || $past(ovf_clear_i[chk_dst_q])))
		else $error("overflow flag not kept");
	sat_val_a: assert property (s_overflow ##0 datapath_saturate_enable_i && !wide_overflow_mode_i |=>
		acc_o[$past(dst_sel)] inside {mua_pkg::SAT32_POS, mua_pkg::SAT32_NEG})
		else $error("narrow saturation value wrong");
	coef_flag_a: assert property (s_overflow ##0 form == mua_pkg::form_coef |=>
		ovf_flag_o[$past(instr_i[13:12])])
		else $error("coefficient form flag wrong");
	tmp3_copy_a: assert property (exec && store_tmp3 |=> temp_o[3] == $past(smem_data_i))
		else $error("temp three copy missing");
	bus_err_a: assert property (berr |=> bus_error_o && !done_o && acc_o == $past(acc_o))
		else $error("external coefficient not refused");
	repeat_a: assert property (exec [*3] |=> done_o && $past(done_o))
		else $error("repeated execution dropped");
	pair_a: assert property (exec && form == mua_pkg::form_imm16 |=> !paired_o && size_o == 3'h4)
		else $error("16-bit form must not pair");
	coef_sum_a: assert property (s_plain(mua_pkg::form_coef) |=>
		acc_o[$past(dst_sel)] == $past(acc_o[dst_sel] + {{6{chk_coef[33]}}, chk_coef}))
		else $error("coefficient form sum wrong");
	imm8_oper_a: assert property (exec && form == mua_pkg::form_imm8 |->
		$signed(mif.opr_b) == $signed(instr_i[23:16]) && mif.opr_a == sext17(temp_o[tmp_sel]))
		else $error("8-bit constant operand wrong");
	swap_dec_a: assert property (instr_valid_i && instr_i[31:25] == 7'h2C && instr_i[17] |->
		exec && form == mua_pkg::form_swap)
		else $error("swapped form not decoded");
	imm8_dec_a: assert property (instr_valid_i && instr_i[31:25] == 7'h0F && instr_i[9] |=>
		done_o && size_o == 3'h3)
		else $error("8-bit immediate form not decoded");
	imm16_dec_a: assert property (instr_valid_i && instr_i[31:24] == 8'h79 && instr_i[1] |=>
		done_o && size_o == 3'h4)
		else $error("16-bit immediate form not decoded");
	legacy_pulse_a: assert property (exec && legacy_compat_mode_i && !wide_overflow_mode_i |=> legacy_exact_o)
		else $error("legacy pulse missing");
endmodule

// ---- verification/mua_mem_model.sv ----
// operand memory model: single operand reads by address byte, a fixed coefficient, external flag from address bit 7
module mua_mem_model (
	input wire logic valid_i,
	input wire logic [7:0] addr_i,
	output logic [15:0] smem_o,
	output logic [15:0] coeff_o,
	output logic external_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// coefficients live in the lower, internal half; the upper half is external on purpose only
	always_comb begin
		external_o = addr_i[7];
		// idle cycles show the inverted pattern, never a stale operand
		smem_o = valid_i ? {addr_i, addr_i} : ~{addr_i, addr_i};
		coeff_o = valid_i ? 16'h4000 : 16'hBFFF;
	end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the multiply-accumulate unit
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin miscompares++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, iv = 0, wr = 0, wa = 0;
	logic [31:0] ins = 0;
	logic [5:0] md = 0;
	logic [3:0] clr = 0;
	logic [1:0] wi = 0;
	logic [39:0] wd = 0;
	logic [15:0] smem, coef;
	logic ext, done, ill, berr, pair, lex;
	logic [3:0][39:0] acc;
	logic [3:0][15:0] tmp;
	logic [3:0] flg;
	logic [2:0] size;
	logic [39:0] ea [4];
	logic [15:0] et [4];
	logic [3:0] ef = 0;
	int miscompares = 0, total_checks = 0;

	// mode bits from bit 0 up: fractional, product saturate, round mode, wide overflow, saturate, legacy
	mua_mac_unit u_dut (
		.clock_i(clk),
		.resetn_i(rst_n),
		.instr_valid_i(iv),
		.instr_i(ins),
		.smem_data_i(smem),
		.coeff_data_i(coef),
		.coeff_external_i(ext),
		.fractional_mode_i(md[0]),
		.mult_saturate_mode_i(md[1]),
		.round_mode_i(md[2]),
		.wide_overflow_mode_i(md[3]),
		.datapath_saturate_enable_i(md[4]),
		.legacy_compat_mode_i(md[5]),
		.ovf_clear_i(clr),
		.reg_wr_i(wr),
		.reg_wr_acc_i(wa),
		.reg_wr_idx_i(wi),
		.reg_wr_data_i(wd),
		.acc_o(acc),
		.temp_o(tmp),
		.ovf_flag_o(flg),
		.done_o(done),
		.illegal_o(ill),
		.bus_error_o(berr),
		.paired_o(pair),
		.size_o(size),
		.legacy_exact_o(lex)
	);

	mua_mem_model u_mem (
		.valid_i(iv),
		.addr_i(ins[23:16]),
		.smem_o(smem),
		.coeff_o(coef),
		.external_o(ext)
	);

	// free-running cpu clock
	initial begin
		forever #20 clk = ~clk;
	end

	function automatic logic [16:0] sx(input logic [15:0] v);
		return {v[15], v};
	endfunction

	// reference arithmetic; the top bit returned is the addition overflow
	function automatic logic [40:0] mac(input logic [39:0] ad, input logic signed [16:0] a,
			input logic signed [16:0] b, input logic rn, input logic [5:0] m);
		logic signed [33:0] p;
		logic [31:0] q;
		logic [40:0] s;
		logic v;
		p = a * b;
		if (m[0]) p = p <<< 1;
		q = p[31:0];
		if (m[1] && m[0] && a == 17'h18000 && b == 17'h18000) q = 32'h7FFFFFFF;
		s = {ad[39], ad} + {{9{q[31]}}, q} + (rn ? 41'h00000008000 : 41'h0);
		if (rn && m[2] && ad[15:0] + q[15:0] == 16'h8000) s[16] = 1'b0;
		if (rn) s[15:0] = 16'h0;
		v = m[3] ? s[40] != s[39] : s[40:31] != 10'h0 && s[40:31] != 10'h3FF;
		if (v && m[4] && m[3]) s[39:0] = s[40] ? 40'h8000000000 : 40'h7FFFFFFFFF;
		if (v && m[4] && !m[3]) s[39:0] = s[40] ? 40'hFF80000000 : 40'h007FFFFFFF;
		return {v, s[39:0]};
	endfunction

	task automatic finish_test;
		if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// every register is compared, so a stray write anywhere shows up
	task automatic chk_all;
		for (int i = 0; i < 4; i++) begin
			`CHK("acc", ea[i], acc[i])
			`CHK("temp", et[i], tmp[i])
		end
		`CHK("flags", ef, flg)
	endtask

	task automatic wrr(input logic a, input logic [1:0] i, input logic [39:0] v);
		@(posedge clk);
		wr <= 1'h1;
		wa <= a;
		wi <= i;
		wd <= v;
		@(posedge clk);
		wr <= 1'h0;
		if (a) ea[i] = v;
		else et[i] = v[15:0];
	endtask

	// one instruction word; the answer lands at the following edge
	task automatic run(input logic [31:0] w, input logic [5:0] m, input logic [2:0] sz, input logic pr,
			input logic [1:0] er, input int d, input logic [40:0] x);
		@(posedge clk);
		iv <= 1'h1;
		ins <= w;
		md <= m;
		@(posedge clk);
		iv <= 1'h0;
		#1;
		`CHK("done", sz != 3'h0, done)
		`CHK("size", sz, size)
		`CHK("paired", pr, pair)
		`CHK("errors", er, {ill, berr})
		`CHK("legacy", sz != 3'h0 && m[5] && !m[3], lex)
		if (d >= 0) begin
			ea[d] = x[39:0];
			ef[d] |= x[40];
		end
		chk_all();
	endtask

	initial begin
		logic [40:0] r;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		#1;
		for (int i = 0; i < 4; i++) begin
			ea[i] = 40'h0;
			et[i] = 16'h0;
		end
		chk_all();
		wrr(1'h1, 2'h1, 40'h0000128002);
		wrr(1'h1, 2'h3, 40'h0000018000);
		wrr(1'h0, 2'h0, 40'h0100);
		wrr(1'h0, 2'h1, 40'hFFFE);
		wrr(1'h0, 2'h2, 40'h8000);
		// register forms, immediates and the fractional cases
		r = mac(ea[0], ea[1][32:16], sx(et[0]), 1'h0, 6'h20);
		run(32'h5710_0000, 6'h20, 3'h2, 1'h1, 2'h0, 0, r);
		r = mac(ea[1], ea[3][32:16], sx(et[1]), 1'h1, 6'h04);
		run(32'h58D7_0000, 6'h04, 3'h2, 1'h0, 2'h0, 3, r);
		r = mac(ea[1], sx(et[1]), 17'h1FF80, 1'h0, 6'h01);
		run(32'h1F80_4600, 6'h01, 3'h3, 1'h1, 2'h0, 0, r);
		r = mac(ea[1], sx(et[0]), 17'h1FFFF, 1'h1, 6'h01);
		run(32'h79FF_FF73, 6'h01, 3'h4, 1'h0, 2'h0, 3, r);
		r = mac(ea[0], sx(et[2]), 17'h18000, 1'h0, 6'h03);
		run(32'h7980_001A, 6'h03, 3'h4, 1'h0, 2'h0, 1, r);
		r = mac(ea[0], sx(et[2]), 17'h18000, 1'h0, 6'h01);
		run(32'h7980_001A, 6'h01, 3'h4, 1'h0, 2'h0, 1, r);
		// coefficient form: store copy, refused external read, both overflow modes
		r = mac(ea[0], 17'h02121, 17'h04000, 1'h0, 6'h00);
		et[3] = 16'h2121;
		run(32'hD121_8400, 6'h00, 3'h3, 1'h0, 2'h0, 0, r);
		run(32'hD180_8400, 6'h00, 3'h0, 1'h0, 2'h1, -1, 41'h0);
		wrr(1'h1, 2'h2, 40'h007FFF0000);
		r = mac(ea[2], 17'h04040, 17'h04000, 1'h0, 6'h10);
		run(32'hD140_2400, 6'h10, 3'h3, 1'h0, 2'h0, 2, r);
		wrr(1'h1, 2'h3, 40'h7FFFFF0000);
		r = mac(ea[3], 17'h04040, 17'h04000, 1'h0, 6'h18);
		run(32'hD140_3400, 6'h18, 3'h3, 1'h0, 2'h0, 3, r);
		run(32'hFF00_0000, 6'h00, 3'h0, 1'h0, 2'h2, -1, 41'h0);
		// back-to-back issue, as a hardware repeat loop delivers it
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			iv <= 1'h1;
			ins <= 32'h5610_0000;
			md <= 6'h00;
			r = mac(ea[0], ea[1][32:16], sx(et[0]), 1'h0, 6'h00);
			ea[0] = r[39:0];
		end
		@(posedge clk);
		iv <= 1'h0;
		#1;
		chk_all();
		// sticky flags drop only when cleared
		@(posedge clk);
		clr <= 4'hC;
		@(posedge clk);
		clr <= 4'h0;
		#1;
		ef &= 4'h3;
		chk_all();
		finish_test();
	end
endmodule
